/* File: low_power_state_control_regs.svh */
`ifndef LOW_POWER_STATE_CONTROL_REGS_SVH
`define LOW_POWER_STATE_CONTROL_REGS_SVH

// synchroniser depth for asynchronous requests
`define LPSC_SYNC_STAGES 2
// number of gated core units (bit 0 bus, bit 1 local interrupt unit, rest core)
`define LPSC_UNITS 4
`define LPSC_UNIT_BUS 0
`define LPSC_UNIT_LIU 1
// clock enable codes: all running, those kept alive in the clocks-stopped state, none in sleep
`define LPSC_EN_ALL 4'hF
`define LPSC_EN_STOPPED 4'h3
`define LPSC_EN_NONE 4'h0
// pending interrupt width
`define LPSC_IRQ_W 8

`endif

/* File: low_power_state_control_pkg.sv */
package low_power_state_control_pkg;
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_STOP_GRANT = 3'b001,
        ST_SLEEP = 3'b010,
        ST_MGMT = 3'b011,
        ST_RESUME = 3'b100
    } power_state_type;
endpackage : low_power_state_control_pkg

/* File: lpsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "low_power_state_control_regs.svh"

// two-flop synchroniser, one bit per lane, reset to the inactive level
module lpsc_sync
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] async_n_i,
    output logic [2:0] sync_n_o
);
    logic [2:0] meta_ff;
    logic [2:0] hold_ff;

    // first stage is read only by the second
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= 3'h7;
            hold_ff <= 3'h7;
        end
        else
        begin
            meta_ff <= async_n_i;
            hold_ff <= meta_ff;
        end
    end

    assign sync_n_o = hold_ff;
endmodule : lpsc_sync

`default_nettype wire

/* File: low_power_state_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "low_power_state_control_regs.svh"

module low_power_state_control
    import low_power_state_control_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic stop_clock_request_n_i,
    input wire logic sleep_request_n_i,
    input wire logic system_mgmt_interrupt_n_i,
    input wire logic over_temp_i,
    input wire logic snoop_req_i,
    input wire logic [`LPSC_IRQ_W-1:0] irq_i,
    input wire logic bus_ack_done_i,
    input wire logic handler_exit_i,
    output logic [`LPSC_UNITS-1:0] unit_clk_en_o,
    output logic stop_grant_ack_o,
    output logic mgmt_ack_o,
    output logic save_state_o,
    output logic system_management_mode_o,
    output logic snoop_resp_o,
    output logic [`LPSC_IRQ_W-1:0] irq_service_o,
    output logic exec_run_o,
    output logic thermal_trip_out_n_o
);
    // enable codes as vectors so each unit flop can pick its own bit
    localparam logic [`LPSC_UNITS-1:0] en_all = `LPSC_EN_ALL;
    localparam logic [`LPSC_UNITS-1:0] en_stopped = `LPSC_EN_STOPPED;
    localparam logic [`LPSC_UNITS-1:0] en_none = `LPSC_EN_NONE;

    // synchronised request levels, active low as on the pins
    logic [2:0] req_sync_n;
    logic stop_req;
    logic sleep_req;
    logic mgmt_req;
    power_state_type state_ff;
    power_state_type nxt_state;
    logic [`LPSC_UNITS-1:0] clk_en_ff;
    logic sg_ack_ff;
    logic mgmt_ack_ff;
    logic save_ff;
    logic mode_ff;
    logic snoop_ff;
    logic [`LPSC_IRQ_W-1:0] pend_ff;
    logic [`LPSC_IRQ_W-1:0] svc_ff;
    logic run_ff;
    logic trip_ff;
    logic mgmt_seen_ff;

    // requests arrive with no relation to the clock
    // every decision below reads only the second flop, so a metastable
    // first stage never fans out into the state logic
    lpsc_sync u_sync
    (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_n_i({system_mgmt_interrupt_n_i, sleep_request_n_i, stop_clock_request_n_i}),
        .sync_n_o(req_sync_n)
    );

    assign stop_req = ~req_sync_n[0];
    assign sleep_req = ~req_sync_n[1];
    assign mgmt_req = ~req_sync_n[2];

    // next power state; thermal trip does not enter into it
    // stop wins over a management request arriving in the same cycle;
    // the management request stays pending and is taken after resume
    // a stop request raised during management mode waits for handler exit
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_NORMAL:
            begin
                if (stop_req)
                    nxt_state = ST_STOP_GRANT;
                else if (mgmt_req && !mgmt_seen_ff)
                    nxt_state = ST_MGMT;
            end
            ST_STOP_GRANT:
            begin
                if (sleep_req)
                    nxt_state = ST_SLEEP;
                else if (!stop_req)
                    nxt_state = ST_RESUME;
            end
            ST_SLEEP:
            begin
                if (!sleep_req)
                    nxt_state = ST_STOP_GRANT;
            end
            ST_MGMT:
            begin
                if (handler_exit_i)
                    nxt_state = ST_NORMAL;
            end
            ST_RESUME:
            begin
                nxt_state = ST_NORMAL;
            end
            default:
            begin
                nxt_state = ST_NORMAL;
            end
        endcase
    end

    // state register; reset always returns to normal
    // reset is synchronous, so it must be held across a clock edge
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            state_ff <= ST_NORMAL;
        else
            state_ff <= nxt_state;
    end

    // management interrupt is level; accept once per assertion
    // without this a long request would re-enter the mode after every exit
    // limitation: a second request needs the pin released in between
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            mgmt_seen_ff <= 1'b0;
        else if (!mgmt_req)
            mgmt_seen_ff <= 1'b0;
        else if (state_ff == ST_NORMAL && nxt_state == ST_MGMT)
            mgmt_seen_ff <= 1'b1;
    end

    // per-unit clock gating, one flop per unit; core_clk_i itself is never gated
    // enables follow the next state so they change together with the state
    genvar ui;
    generate
        for (ui = 0; ui < `LPSC_UNITS; ui = ui + 1)
        begin : g_unit_gate
            always_ff @(posedge core_clk_i)
            begin
                if (rst_i)
                    clk_en_ff[ui] <= en_all[ui];
                else
                begin
                    unique case (nxt_state)
                        ST_STOP_GRANT: clk_en_ff[ui] <= en_stopped[ui];
                        ST_SLEEP: clk_en_ff[ui] <= en_none[ui];
                        default: clk_en_ff[ui] <= en_all[ui];
                    endcase
                end
            end
        end
    endgenerate

    // one-cycle stop-grant acknowledge transaction request on entry from normal
    // a return from sleep is not a new entry, so no second acknowledge
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            sg_ack_ff <= 1'b0;
        else
            sg_ack_ff <= (state_ff == ST_NORMAL) && (nxt_state == ST_STOP_GRANT);
    end

    // management entry: save pulse, then acknowledge, then handler runs
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            save_ff <= 1'b0;
            mgmt_ack_ff <= 1'b0;
        end
        else
        begin
            // acknowledge trails the save by one cycle so state is safe first
            save_ff <= (state_ff == ST_NORMAL) && (nxt_state == ST_MGMT);
            mgmt_ack_ff <= save_ff;
        end
    end

    // mode flag rises with the acknowledge so the handler starts after it
    // it drops one cycle after the handler exit, when the state has left
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            mode_ff <= 1'b0;
        else if (state_ff != ST_MGMT)
            mode_ff <= 1'b0;
        else if (save_ff)
            mode_ff <= 1'b1;
    end

    // snoops answered in normal and stop-grant, dropped in sleep
    // the bus unit keeps its clock in stop-grant, which is what lets it answer
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            snoop_ff <= 1'b0;
        else
            snoop_ff <= snoop_req_i && (state_ff != ST_SLEEP);
    end

    // pending interrupts; a new one wins over the clear in the same cycle
    // stop-grant only collects, so nothing is lost while the core is gated
    // arrivals in sleep are dropped: the interrupt unit has no clock there
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            pend_ff <= '0;
        else if (state_ff == ST_SLEEP)
            pend_ff <= pend_ff;
        else if (state_ff == ST_STOP_GRANT)
            pend_ff <= pend_ff | irq_i;
        else
            pend_ff <= (pend_ff & ~svc_ff) | irq_i;
    end

    // service strobe, one cycle per handed-off set, only while executing
    // the gap cycle after each strobe lets the pending clear land first,
    // trading one cycle of latency for never serving an interrupt twice unless its strobe falls on the edge into stop-grant
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            svc_ff <= '0;
        else if ((state_ff == ST_NORMAL || state_ff == ST_RESUME) && run_ff && !trip_ff
                 && svc_ff == '0)
            svc_ff <= pend_ff;
        else
            svc_ff <= '0;
    end

    // thermal trip latch; reset re-evaluates, no hysteresis
    // a part still hot at reset release trips again on the first edge,
    // so the pin is only meaningful once reset has been released
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            trip_ff <= 1'b0;
        else if (over_temp_i)
            trip_ff <= 1'b1;
    end

    // execution runs only when clocked core and not tripped
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            run_ff <= 1'b0;
        else
            run_ff <= !trip_ff && !over_temp_i
                      && (nxt_state == ST_NORMAL || nxt_state == ST_MGMT);
    end

    // bus ack done is informative only; the block never waits on it
    logic unused_ok;
    assign unused_ok = bus_ack_done_i;

    // every output is a flop, the trip pin through one inverter, so no glitch reaches the system side
    assign unit_clk_en_o = clk_en_ff;
    assign stop_grant_ack_o = sg_ack_ff;
    // management entry handshake
    assign mgmt_ack_o = mgmt_ack_ff;
    assign save_state_o = save_ff;
    assign system_management_mode_o = mode_ff;
    // bus, interrupt and execution status
    assign snoop_resp_o = snoop_ff;
    assign irq_service_o = svc_ff;
    assign exec_run_o = run_ff;
    assign thermal_trip_out_n_o = ~trip_ff;
endmodule : low_power_state_control

`default_nettype wire

/* File: lpsc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "low_power_state_control_regs.svh"
// power-state outputs tied to the request pins that cause them
module lpsc_checker
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic stop_clock_request_n_i,
    input wire logic sleep_request_n_i,
    input wire logic over_temp_i,
    input wire logic snoop_req_i,
    input wire logic [`LPSC_UNITS-1:0] unit_clk_en_o,
    input wire logic stop_grant_ack_o,
    input wire logic mgmt_ack_o,
    input wire logic save_state_o,
    input wire logic system_management_mode_o,
    input wire logic snoop_resp_o,
    input wire logic exec_run_o,
    input wire logic thermal_trip_out_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // windows allow for the two synchroniser flops
    stop_enter_a: assert property ($fell(stop_clock_request_n_i) && unit_clk_en_o == 4'hF
        && !system_management_mode_o |-> ##[2:4] unit_clk_en_o == 4'h3) else $error("no stop");
    grant_ack_a: assert property (stop_grant_ack_o |->
        unit_clk_en_o == 4'h3 ##1 !stop_grant_ack_o) else $error("bad ack");
    snoop_kept_a: assert property (snoop_req_i && unit_clk_en_o == 4'h3
        |=> snoop_resp_o) else $error("snoop lost");
    resume_run_a: assert property ($rose(stop_clock_request_n_i) && unit_clk_en_o == 4'h3
        |-> ##[2:4] unit_clk_en_o == 4'hF ##[1:2] exec_run_o) else $error("no resume");
    sleep_enter_a: assert property ($fell(sleep_request_n_i) && unit_clk_en_o == 4'h3
        |-> ##[2:4] unit_clk_en_o == 4'h0) else $error("no sleep");
    sleep_exit_a: assert property ($rose(sleep_request_n_i) && unit_clk_en_o == 4'h0
        |-> ##[2:4] unit_clk_en_o == 4'h3) else $error("no wake");
    mgmt_order_a: assert property (save_state_o
        |=> mgmt_ack_o && system_management_mode_o) else $error("bad mgmt entry");
    trip_set_a: assert property (over_temp_i
        |=> !thermal_trip_out_n_o && !exec_run_o) else $error("no trip");
    trip_hold_a: assert property (!thermal_trip_out_n_o
        |=> !thermal_trip_out_n_o && !exec_run_o) else $error("trip lost");
endmodule : lpsc_checker

bind low_power_state_control lpsc_checker i_chk(.core_clk_i, .rst_i, .stop_clock_request_n_i,
    .sleep_request_n_i, .over_temp_i, .snoop_req_i, .unit_clk_en_o, .stop_grant_ack_o,
    .mgmt_ack_o, .save_state_o, .system_management_mode_o, .snoop_resp_o, .exec_run_o,
    .thermal_trip_out_n_o);
`default_nettype wire

/* File: lpsc_chipset_model.sv */
`timescale 1ns/1ps
`default_nettype none
// system side: bench requests become active-low asynchronous pins
module lpsc_chipset_model
(
    input wire logic core_clk_i,
    input wire logic [2:0] req_i,
    output logic stop_n_o,
    output logic sleep_n_o,
    output logic mgmt_n_o
);
    initial {stop_n_o, sleep_n_o, mgmt_n_o} = 3'h7;
    // odd skew keeps the pins off the clock edge
    always @(posedge core_clk_i)
    begin
        #3;
        stop_n_o <= ~req_i[0];
        sleep_n_o <= ~(req_i[1] & req_i[0]); // only on top of a stop
        mgmt_n_o <= ~req_i[2];
    end
endmodule : lpsc_chipset_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_i, hot, snp, hexit, ack, sack, save, mode, sresp, run, trip_n;
    logic stop_n, sleep_n, mgmt_n;
    logic [2:0] req;
    logic [7:0] irq, svc, r;
    logic [3:0] en;
    logic [7:0] svc_q[$];
    logic [7:0] ack_q[$];
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'h2f6f;
    lpsc_chipset_model i_model(.core_clk_i(clk), .req_i(req), .stop_n_o(stop_n),
        .sleep_n_o(sleep_n), .mgmt_n_o(mgmt_n));
    low_power_state_control i_dut(.core_clk_i(clk), .rst_i(rst_i), .stop_clock_request_n_i(stop_n),
        .sleep_request_n_i(sleep_n), .system_mgmt_interrupt_n_i(mgmt_n), .over_temp_i(hot),
        .snoop_req_i(snp), .irq_i(irq), .bus_ack_done_i(1'b0), .handler_exit_i(hexit),
        .unit_clk_en_o(en), .stop_grant_ack_o(ack), .mgmt_ack_o(sack), .save_state_o(save),
        .system_management_mode_o(mode), .snoop_resp_o(sresp), .irq_service_o(svc),
        .exec_run_o(run), .thermal_trip_out_n_o(trip_n));
    task automatic check(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // result watcher: the oldest note is matched against each pulse
    always @(posedge clk)
    begin
        #2;
        if (ack === 1'b1) check("clk_en", ack_q.size() ? ack_q.pop_front() : 8'hXX, 8'(en));
        if (svc !== 8'h00) check("svc", svc_q.size() ? svc_q.pop_front() : 8'hXX, svc);
    end
    initial
    begin
        #20000;
        num_errors++;
        give_verdict();
    end
    initial
    begin
        {rst_i, req, hot, snp, irq, hexit} = {1'b1, 14'h0};
        tick(2);
        rst_i = 0;
        tick(4);
        req[0] = 1;
        ack_q.push_back(8'h03);
        tick(6);
        r = 8'($random(seed)) | 8'h01;
        irq = r; // latched while clocks are stopped
        snp = 1;
        svc_q.push_back(r);
        tick(1);
        {irq, snp} = 9'h0;
        check("snoop", 8'h01, 8'(sresp));
        req[1] = 1;
        tick(6);
        check("sleep_en", 8'h00, 8'(en));
        irq = 8'($random(seed)) | 8'h80; // must be dropped, not latched
        snp = 1;
        tick(1);
        {irq, snp} = 9'h0;
        check("snoop", 8'h00, 8'(sresp));
        req[1] = 0;
        tick(6);
        check("wake_en", 8'h03, 8'(en));
        req[0] = 0;
        tick(6);
        check("run_en", 8'h1F, {3'h0, run, en});
        req[2] = 1;
        tick(8);
        check("mgmt_mode", 8'h01, 8'(mode));
        req[2] = 0;
        hexit = 1;
        tick(1);
        hexit = 0;
        tick(1);
        check("mgmt_mode", 8'h00, 8'(mode));
        hot = 1;
        tick(1);
        hot = 0;
        tick(4);
        check("trip_run", 8'h00, {6'h0, trip_n, run});
        {hot, rst_i} = 2'h3; // still hot across reset
        tick(2);
        rst_i = 0;
        tick(3);
        check("trip_run", 8'h00, {6'h0, trip_n, run});
        {hot, rst_i} = 2'h1;
        tick(2);
        rst_i = 0;
        tick(3);
        check("trip_run", 8'h03, {6'h0, trip_n, run});
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
